/* File: rtl/line_afe_ctrl.sv */
// Purpose: Control and status registers for comparator 1 trim, polarity, hysteresis and amplifier trim
// Assumes: Single clock mclk at 125 MHz; raw analog outputs arrive asynchronously
// Notes: The trim search itself is run by software through these registers
`include "line_afe_defines.svh"
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Cmp1 trim-mode bit selects calibration mode
// - Cmp1 reference select: negative or positive input
// - Cmp1 5-bit trim, resets 10000
// - Unimplemented bits read zero, ignore writes
// - Output select forwards cmp0 or cmp1
// - Cmp1 invert bit flips raw output
// - Cmp0 invert bit flips raw output
// - Two 2-bit hysteresis fields to comparators
// - Amp enable; disabled output is high impedance
// - Amp status follows output in trim mode
// - Bandwidth bit: 600kHz or 2MHz
// - Amp trim-mode bit selects calibration mode
// - Amp reference select: inverting or non-inverting
// - Amp 6-bit trim, resets 100000
// - Debounced output needs N agreeing samples
module line_afe_ctrl #(
  parameter int DEB_W = 7
) (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [`ADDR_W-1:0] addr, // Register index
  input wire logic [`DATA_W-1:0] wdata, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  output logic [`DATA_W-1:0] rdata, // Read data, cycle after strobe
  input wire logic cmp0_analog, // Comparator 0 analog output, asynchronous
  input wire logic cmp1_analog, // Comparator 1 analog output, asynchronous
  input wire logic amp_analog, // Amplifier output level, asynchronous
  output logic cmp1_trim_mode, // Comparator 1 calibration mode
  output logic cmp1_trim_ref_sel, // Comparator 1 calibration reference
  output logic [4:0] cmp1_trim_value, // Comparator 1 offset trim
  output logic [1:0] cmp1_hysteresis, // Comparator 1 hysteresis window
  output logic [1:0] cmp0_hysteresis, // Comparator 0 hysteresis window
  output logic amp_enable, // Amplifier power on
  output logic amp_out_oe, // Amplifier output pin drive enable
  output logic amp_bandwidth_sel, // 0 600kHz, 1 2MHz
  output logic amp_trim_mode, // Amplifier calibration mode
  output logic amp_trim_ref_sel, // Amplifier calibration reference
  output logic [5:0] amp_trim_value, // Amplifier offset trim
  output logic cmp_selected_out // Selected debounced comparator output
);

  // Refused at elaboration: a narrower counter cannot reach the longest window
  if (DEB_W < 7) begin : g_deb_w_check
    $error("DEB_W too small for longest debounce");
  end

  logic [6:0] cmp1_trim_ff, nxt_cmp1_trim;
  logic [6:0] pol_hys_ff, nxt_pol_hys;
  logic [1:0] amp_ctrl_ff, nxt_amp_ctrl;
  logic [7:0] amp_trim_ff, nxt_amp_trim;
  logic [3:0] deb_cfg_ff, nxt_deb_cfg;
  logic [`DATA_W-1:0] rdata_ff, nxt_rdata;

  logic [2:0] sync1_ff, sync2_ff;
  logic cmp0_raw_out, cmp1_raw_out, amp_status;
  logic [1:0] deb_out_ff, nxt_deb_out;
  logic [DEB_W-1:0] deb_cnt_ff [2];
  logic [DEB_W-1:0] nxt_deb_cnt [2];
  logic [1:0] raw_vec;

  // Disagreeing samples needed beyond the first for a debounce selection
  function automatic logic [DEB_W-1:0] deb_limit(input logic [1:0] sel);
    case (line_afe_pkg::deb_sel_type'(sel))
      line_afe_pkg::deb_short: deb_limit = DEB_W'(`DEB_SHORT);
      line_afe_pkg::deb_mid: deb_limit = DEB_W'(`DEB_MID);
      line_afe_pkg::deb_long: deb_limit = DEB_W'(`DEB_LONG);
      default: deb_limit = '0;
    endcase
  endfunction

  // Analog levels are asynchronous, so two flops before any use
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
    end else begin
      sync1_ff <= {amp_analog, cmp1_analog, cmp0_analog};
      sync2_ff <= sync1_ff;
    end
  end

  assign cmp0_raw_out = sync2_ff[0] ^ pol_hys_ff[`CMP0_INV_BIT];
  assign cmp1_raw_out = sync2_ff[1] ^ pol_hys_ff[`CMP1_INV_BIT];
  assign amp_status = amp_trim_ff[`AMP_TRIM_MODE_BIT] & sync2_ff[2];
  assign raw_vec = {cmp1_raw_out, cmp0_raw_out};

  // Register writes and read mux
  always_comb begin
    nxt_cmp1_trim = cmp1_trim_ff;
    nxt_pol_hys = pol_hys_ff;
    nxt_amp_ctrl = amp_ctrl_ff;
    nxt_amp_trim = amp_trim_ff;
    nxt_deb_cfg = deb_cfg_ff;
    nxt_rdata = 8'h00;
    if (wr_en) begin
      case (addr)
        `OFS_CMP1_TRIM: nxt_cmp1_trim = wdata[6:0];
        `OFS_CMP_POL_HYS: nxt_pol_hys = wdata[6:0];
        `OFS_AMP_CTRL: nxt_amp_ctrl = {wdata[`AMP_EN_BIT], wdata[`AMP_BW_BIT]};
        `OFS_AMP_TRIM: nxt_amp_trim = wdata;
        `OFS_CMP_DEB: nxt_deb_cfg = wdata[3:0];
        default: ;
      endcase
    end
    if (rd_en) begin
      case (addr)
        `OFS_CMP1_TRIM: nxt_rdata = {1'b0, cmp1_trim_ff};
        `OFS_CMP_POL_HYS: nxt_rdata = {1'b0, pol_hys_ff};
        `OFS_AMP_CTRL: nxt_rdata = {1'b0, amp_ctrl_ff[1], amp_status, 4'h0, amp_ctrl_ff[0]};
        `OFS_AMP_TRIM: nxt_rdata = amp_trim_ff;
        `OFS_CMP_DEB: nxt_rdata = {4'h0, deb_cfg_ff};
        `OFS_CMP_STATUS: nxt_rdata = {4'h0, deb_out_ff, raw_vec};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmp1_trim_ff <= {2'h0, `CMP1_TRIM_RST};
      pol_hys_ff <= 7'h00;
      amp_ctrl_ff <= 2'h0;
      amp_trim_ff <= {2'h0, `AMP_TRIM_RST};
      deb_cfg_ff <= 4'h0;
      rdata_ff <= 8'h00;
    end else begin
      cmp1_trim_ff <= nxt_cmp1_trim;
      pol_hys_ff <= nxt_pol_hys;
      amp_ctrl_ff <= nxt_amp_ctrl;
      amp_trim_ff <= nxt_amp_trim;
      deb_cfg_ff <= nxt_deb_cfg;
      rdata_ff <= nxt_rdata;
    end
  end

  // Debounce: counter restarts whenever raw agrees with output
  always_comb begin
    nxt_deb_out = deb_out_ff;
    for (int i = 0; i < 2; i++) begin
      nxt_deb_cnt[i] = '0;
      if (raw_vec[i] != deb_out_ff[i]) begin
        if (deb_cnt_ff[i] >= deb_limit(deb_cfg_ff[2*i+:2])) begin
          nxt_deb_out[i] = raw_vec[i];
        end else begin
          nxt_deb_cnt[i] = deb_cnt_ff[i] + DEB_W'(1);
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      deb_out_ff <= 2'h0;
      deb_cnt_ff[0] <= '0;
      deb_cnt_ff[1] <= '0;
    end else begin
      deb_out_ff <= nxt_deb_out;
      deb_cnt_ff[0] <= nxt_deb_cnt[0];
      deb_cnt_ff[1] <= nxt_deb_cnt[1];
    end
  end

  assign rdata = rdata_ff;
  assign cmp1_trim_mode = cmp1_trim_ff[`CMP1_TRIM_MODE_BIT];
  assign cmp1_trim_ref_sel = cmp1_trim_ff[`CMP1_REF_SEL_BIT];
  assign cmp1_trim_value = cmp1_trim_ff[4:0];
  assign cmp1_hysteresis = pol_hys_ff[3:2];
  assign cmp0_hysteresis = pol_hys_ff[1:0];
  assign amp_enable = amp_ctrl_ff[1];
  assign amp_out_oe = amp_ctrl_ff[1];
  assign amp_bandwidth_sel = amp_ctrl_ff[0];
  assign amp_trim_mode = amp_trim_ff[`AMP_TRIM_MODE_BIT];
  assign amp_trim_ref_sel = amp_trim_ff[`AMP_REF_SEL_BIT];
  assign amp_trim_value = amp_trim_ff[5:0];
  // Debounced output chosen by select bit
  assign cmp_selected_out = pol_hys_ff[`CMP_OSEL_BIT] ? deb_out_ff[1] : deb_out_ff[0];

  property p_cmp1_trim_write;
    @(posedge mclk) disable iff (!rst_n)
    (wr_en && addr == `OFS_CMP1_TRIM) |=> (cmp1_trim_value == $past(wdata[4:0]) &&
      cmp1_trim_mode == $past(wdata[6]));
  endproperty
  a_cmp1_trim_write: assert property (p_cmp1_trim_write) else $error("cmp1 trim write lost");

  property p_amp_status_low;
    @(posedge mclk) disable iff (!rst_n)
    (rd_en && addr == `OFS_AMP_CTRL && !amp_trim_mode) |=> (rdata[`AMP_STATUS_BIT] == 1'b0);
  endproperty
  a_amp_status_low: assert property (p_amp_status_low) else $error("amp status not low");

  property p_amp_ctrl_zero;
    @(posedge mclk) disable iff (!rst_n)
    (rd_en && addr == `OFS_AMP_CTRL) |=> (rdata[7] == 1'b0 && rdata[4:1] == 4'h0);
  endproperty
  a_amp_ctrl_zero: assert property (p_amp_ctrl_zero) else $error("amp ctrl reserved bits set");

  property p_amp_oe;
    @(posedge mclk) disable iff (!rst_n)
    (amp_out_oe == amp_enable);
  endproperty
  a_amp_oe: assert property (p_amp_oe) else $error("amp pin drive mismatch");

  property p_sel_out;
    @(posedge mclk) disable iff (!rst_n)
    (wr_en && addr == `OFS_CMP_POL_HYS) ##1 $stable(deb_out_ff) |->
      cmp_selected_out == ($past(wdata[6]) ? deb_out_ff[1] : deb_out_ff[0]);
  endproperty
  a_sel_out: assert property (p_sel_out) else $error("output select wrong");

  property p_amp_trim_write;
    @(posedge mclk) disable iff (!rst_n)
    (wr_en && addr == `OFS_AMP_TRIM) |=> (amp_trim_value == $past(wdata[5:0]) &&
      amp_trim_ref_sel == $past(wdata[6]));
  endproperty
  a_amp_trim_write: assert property (p_amp_trim_write) else $error("amp trim write lost");

  property p_nodeb_follow;
    @(posedge mclk) disable iff (!rst_n)
    (deb_cfg_ff[1:0] == 2'h0 && !wr_en)[*2] |-> deb_out_ff[0] == $past(raw_vec[0]);
  endproperty
  a_nodeb_follow: assert property (p_nodeb_follow) else $error("debounce bypass slow");

  property p_deb_hold;
    @(posedge mclk) disable iff (!rst_n)
    (deb_cfg_ff[1:0] == 2'h1 && raw_vec[0] != deb_out_ff[0] && deb_cnt_ff[0] == '0) |=> $stable(deb_out_ff[0]);
  endproperty
  a_deb_hold: assert property (p_deb_hold) else $error("debounce changed too early");

  property p_hys_write;
    @(posedge mclk) disable iff (!rst_n)
    (wr_en && addr == `OFS_CMP_POL_HYS) |=> ({cmp1_hysteresis, cmp0_hysteresis} == $past(wdata[3:0]));
  endproperty
  a_hys_write: assert property (p_hys_write) else $error("hysteresis write lost");

  property p_cmp1_ref_write;
    @(posedge mclk) disable iff (!rst_n)
    (wr_en && addr == `OFS_CMP1_TRIM) |=> (cmp1_trim_ref_sel == $past(wdata[`CMP1_REF_SEL_BIT]));
  endproperty
  a_cmp1_ref_write: assert property (p_cmp1_ref_write) else $error("cmp1 reference select lost");

  // Control outputs must only move on a write to their own register
  property p_cmp1_mode_hold;
    @(posedge mclk) disable iff (!rst_n)
    !(wr_en && addr == `OFS_CMP1_TRIM) |=> $stable(cmp1_trim_mode);
  endproperty
  a_cmp1_mode_hold: assert property (p_cmp1_mode_hold) else $error("cmp1 trim mode moved");

  property p_cmp1_trim_hold;
    @(posedge mclk) disable iff (!rst_n)
    !(wr_en && addr == `OFS_CMP1_TRIM) |=> $stable(cmp1_trim_value);
  endproperty
  a_cmp1_trim_hold: assert property (p_cmp1_trim_hold) else $error("cmp1 trim moved");

  property p_cmp1_rd_top;
    @(posedge mclk) disable iff (!rst_n)
    (rd_en && addr == `OFS_CMP1_TRIM) |=> (rdata[7] == 1'b0);
  endproperty
  a_cmp1_rd_top: assert property (p_cmp1_rd_top) else $error("cmp1 trim top bit set");

  property p_pol_rd_top;
    @(posedge mclk) disable iff (!rst_n)
    (rd_en && addr == `OFS_CMP_POL_HYS) |=> (rdata[7] == 1'b0);
  endproperty
  a_pol_rd_top: assert property (p_pol_rd_top) else $error("polarity top bit set");

  property p_hys_hold;
    @(posedge mclk) disable iff (!rst_n)
    !(wr_en && addr == `OFS_CMP_POL_HYS) |=> $stable({cmp1_hysteresis, cmp0_hysteresis});
  endproperty
  a_hys_hold: assert property (p_hys_hold) else $error("hysteresis moved");

  property p_cmp1_inv_status;
    @(posedge mclk) disable iff (!rst_n)
    (rd_en && addr == `OFS_CMP_STATUS) |=> (rdata[1] == ($past(sync2_ff[1]) ^ $past(pol_hys_ff[`CMP1_INV_BIT])));
  endproperty
  a_cmp1_inv_status: assert property (p_cmp1_inv_status) else $error("cmp1 polarity wrong");

  property p_cmp0_inv_status;
    @(posedge mclk) disable iff (!rst_n)
    (rd_en && addr == `OFS_CMP_STATUS) |=> (rdata[0] == ($past(sync2_ff[0]) ^ $past(pol_hys_ff[`CMP0_INV_BIT])));
  endproperty
  a_cmp0_inv_status: assert property (p_cmp0_inv_status) else $error("cmp0 polarity wrong");

  property p_amp_en_write;
    @(posedge mclk) disable iff (!rst_n)
    (wr_en && addr == `OFS_AMP_CTRL) |=> (amp_enable == $past(wdata[`AMP_EN_BIT]));
  endproperty
  a_amp_en_write: assert property (p_amp_en_write) else $error("amp enable write lost");

  property p_amp_bw_write;
    @(posedge mclk) disable iff (!rst_n)
    (wr_en && addr == `OFS_AMP_CTRL) |=> (amp_bandwidth_sel == $past(wdata[`AMP_BW_BIT]));
  endproperty
  a_amp_bw_write: assert property (p_amp_bw_write) else $error("amp bandwidth write lost");

  property p_amp_ctrl_hold;
    @(posedge mclk) disable iff (!rst_n)
    !(wr_en && addr == `OFS_AMP_CTRL) |=> ($stable(amp_enable) && $stable(amp_bandwidth_sel));
  endproperty
  a_amp_ctrl_hold: assert property (p_amp_ctrl_hold) else $error("amp control moved");

  // Status must show the synchronised level, not a stale or inverted one
  property p_amp_status_follow;
    @(posedge mclk) disable iff (!rst_n)
    (rd_en && addr == `OFS_AMP_CTRL && amp_trim_mode) |=> (rdata[`AMP_STATUS_BIT] == $past(sync2_ff[2]));
  endproperty
  a_amp_status_follow: assert property (p_amp_status_follow) else $error("amp status not following");

  property p_amp_mode_write;
    @(posedge mclk) disable iff (!rst_n)
    (wr_en && addr == `OFS_AMP_TRIM) |=> (amp_trim_mode == $past(wdata[`AMP_TRIM_MODE_BIT]));
  endproperty
  a_amp_mode_write: assert property (p_amp_mode_write) else $error("amp trim mode write lost");

  property p_amp_ref_hold;
    @(posedge mclk) disable iff (!rst_n)
    !(wr_en && addr == `OFS_AMP_TRIM) |=> $stable(amp_trim_ref_sel);
  endproperty
  a_amp_ref_hold: assert property (p_amp_ref_hold) else $error("amp reference moved");

  property p_amp_trim_hold;
    @(posedge mclk) disable iff (!rst_n)
    !(wr_en && addr == `OFS_AMP_TRIM) |=> $stable(amp_trim_value);
  endproperty
  a_amp_trim_hold: assert property (p_amp_trim_hold) else $error("amp trim moved");

  // A debounced edge may only ever move toward the raw level
  property p_deb_toward_raw;
    @(posedge mclk) disable iff (!rst_n)
    $changed(deb_out_ff[0]) |-> (deb_out_ff[0] == $past(raw_vec[0]));
  endproperty
  a_deb_toward_raw: assert property (p_deb_toward_raw) else $error("debounce moved away from raw");

  property p_deb_restart;
    @(posedge mclk) disable iff (!rst_n)
    (raw_vec[0] == deb_out_ff[0]) |=> (deb_cnt_ff[0] == '0);
  endproperty
  a_deb_restart: assert property (p_deb_restart) else $error("debounce count not restarted");

endmodule // line_afe_ctrl

`default_nettype wire

/* File: rtl/line_afe_defines.svh */
// Purpose: Register offsets, field positions and reset values for the line front-end control block
// Assumes: Byte-wide registers on a plain strobe port
// Notes: Offsets are local word indices
`ifndef LINE_AFE_DEFINES_SVH
`define LINE_AFE_DEFINES_SVH

`define ADDR_W 4
`define DATA_W 8
`define OFS_CMP1_TRIM 4'h0
`define OFS_CMP_POL_HYS 4'h1
`define OFS_AMP_CTRL 4'h2
`define OFS_AMP_TRIM 4'h3
`define OFS_CMP_DEB 4'h4
`define OFS_CMP_STATUS 4'h5

`define CMP1_TRIM_MODE_BIT 6
`define CMP1_REF_SEL_BIT 5
`define CMP1_TRIM_RST 5'h10
`define CMP_OSEL_BIT 6
`define CMP1_INV_BIT 5
`define CMP0_INV_BIT 4
`define AMP_EN_BIT 6
`define AMP_STATUS_BIT 5
`define AMP_BW_BIT 0
`define AMP_TRIM_MODE_BIT 7
`define AMP_REF_SEL_BIT 6
`define AMP_TRIM_RST 6'h20

`define DEB_SHORT 7'h20
`define DEB_MID 7'h40
`define DEB_LONG 7'h7F

`endif

/* File: rtl/line_afe_pkg.sv */
// Purpose: Shared types for the line front-end control block
// Assumes: Nothing beyond the defines header
// Notes: Debounce selection encoding
package line_afe_pkg;
  typedef enum logic [1:0] {
    deb_none,
    deb_short,
    deb_mid,
    deb_long
  } deb_sel_type;
endpackage

/* File: sim/tb_top.sv */
// Purpose: Self-checking bench for the line front-end control registers
// Assumes: Read data stands only in the cycle after the read strobe
// Notes: Amplifier output is modelled as a fixed threshold on the applied trim
`include "line_afe_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [5:0] AMP_THR = 6'h17;
  localparam logic [4:0] C1_THR = 5'h0B;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [`ADDR_W-1:0] addr = 4'h0;
  logic [`DATA_W-1:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic c0_in = 1'b0;
  logic c1_in = 1'b0;
  logic a_in = 1'b0;
  logic [`DATA_W-1:0] rdata;
  logic c1_mode, c1_ref, a_en, a_oe, a_bw, a_mode, a_ref, sel_out;
  logic [4:0] c1_val;
  logic [1:0] c1_hys, c0_hys;
  logic [5:0] a_val;
  int n_errors = 0;
  int n_checks = 0;
  logic [7:0] d;
  logic [5:0] t1, t2;
  logic [6:0] sum;
  logic [7:0] pol_cfg [4] = '{8'h00, 8'h40, 8'h60, 8'h50};
  logic pol_exp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  line_afe_ctrl uut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .cmp0_analog(c0_in), .cmp1_analog(c1_in), .amp_analog(a_in), .cmp1_trim_mode(c1_mode),
    .cmp1_trim_ref_sel(c1_ref), .cmp1_trim_value(c1_val), .cmp1_hysteresis(c1_hys), .cmp0_hysteresis(c0_hys),
    .amp_enable(a_en), .amp_out_oe(a_oe), .amp_bandwidth_sel(a_bw), .amp_trim_mode(a_mode),
    .amp_trim_ref_sel(a_ref), .amp_trim_value(a_val), .cmp_selected_out(sel_out));

  always #4 mclk = ~mclk;
  // Amplifier flips once the applied trim reaches its offset point
  always @(posedge mclk) a_in <= (a_val >= AMP_THR);
  // Comparator 1 flips at its offset point, only while in calibration
  always @(posedge mclk) c1_in <= c1_mode & (c1_val >= C1_THR);

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask

  // Software trim search; waits a settle time after every trim write
  task automatic search(input logic cmp, input logic [5:0] start, input logic up, output logic [5:0] thr);
    logic first;
    logic done;
    thr = start;
    done = 1'b0;
    wr(cmp ? `OFS_CMP1_TRIM : `OFS_AMP_TRIM, cmp ? {3'b011, thr[4:0]} : {2'b11, thr});
    repeat (4) @(posedge mclk);
    rd(cmp ? `OFS_CMP_STATUS : `OFS_AMP_CTRL, d);
    first = cmp ? d[1] : d[5];
    for (int i = 0; i < 63 && !done; i++) begin
      thr = up ? thr + 6'h01 : thr - 6'h01;
      wr(cmp ? `OFS_CMP1_TRIM : `OFS_AMP_TRIM, cmp ? {3'b011, thr[4:0]} : {2'b11, thr});
      repeat (4) @(posedge mclk);
      rd(cmp ? `OFS_CMP_STATUS : `OFS_AMP_CTRL, d);
      done = ((cmp ? d[1] : d[5]) !== first);
    end
  endtask

  task automatic end_of_test;
    if (n_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    end_of_test;
  end

  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    #1 chk({c1_mode, c1_ref, 1'b0, c1_val}, 8'h10);
    chk({a_mode, a_ref, a_val}, 8'h20);
    chk({a_en, a_oe, a_bw, c1_hys, c0_hys}, 8'h00);
    rd(`OFS_CMP1_TRIM, d); chk(d, 8'h10);
    rd(`OFS_CMP_POL_HYS, d); chk(d, 8'h00);
    rd(`OFS_AMP_CTRL, d); chk(d, 8'h00);
    rd(`OFS_AMP_TRIM, d); chk(d, 8'h20);
    wr(`OFS_CMP1_TRIM, 8'hFF); chk({c1_mode, c1_ref, 1'b0, c1_val}, 8'hDF);
    rd(`OFS_CMP1_TRIM, d); chk(d, 8'h7F);
    wr(`OFS_CMP_POL_HYS, 8'h89); chk({4'h0, c1_hys, c0_hys}, 8'h09);
    rd(`OFS_CMP_POL_HYS, d); chk(d, 8'h09);
    wr(`OFS_AMP_CTRL, 8'hFF); chk({5'h00, a_en, a_oe, a_bw}, 8'h07);
    rd(`OFS_AMP_CTRL, d); chk(d, 8'h41);
    wr(4'hF, 8'hFF);
    rd(4'hF, d); chk(d, 8'h00);
    rd(`OFS_CMP1_TRIM, d); chk(d, 8'h7F);
    wr(`OFS_AMP_TRIM, 8'hC5); chk({a_mode, a_ref, a_val}, 8'hC5);
    rd(`OFS_AMP_TRIM, d); chk(d, 8'hC5);
    // Calibration search, first upward then downward
    search(1'b0, 6'h00, 1'b1, t1); chk({2'b00, t1}, {2'b00, AMP_THR});
    search(1'b0, 6'h3F, 1'b0, t2); chk({2'b00, t2}, {2'b00, AMP_THR - 6'h01});
    sum = {1'b0, t1} + {1'b0, t2};
    wr(`OFS_AMP_TRIM, {2'b00, sum[6:1]});
    rd(`OFS_AMP_TRIM, d); chk(d, 8'h16);
    repeat (4) @(posedge mclk);
    rd(`OFS_AMP_CTRL, d); chk(d, 8'h41);
    // Comparator 1 calibration search, ending back in normal mode
    search(1'b1, 6'h00, 1'b1, t1); chk({2'b00, t1}, {3'b000, C1_THR});
    search(1'b1, 6'h1F, 1'b0, t2); chk({2'b00, t2}, {3'b000, C1_THR - 5'h01});
    sum = {1'b0, t1} + {1'b0, t2};
    wr(`OFS_CMP1_TRIM, {3'b000, sum[5:1]});
    rd(`OFS_CMP1_TRIM, d); chk(d, 8'h0A);
    // Polarity and output select, no debounce
    wr(`OFS_CMP_DEB, 8'h00);
    c0_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_CMP_POL_HYS, pol_cfg[i]);
      repeat (5) @(posedge mclk);
      #1 chk({7'h00, sel_out}, {7'h00, pol_exp[i]});
    end
    wr(`OFS_CMP_POL_HYS, 8'h60);
    repeat (5) @(posedge mclk);
    rd(`OFS_CMP_STATUS, d); chk(d, 8'h0F);
    // Short debounce on comparator 0
    wr(`OFS_CMP_POL_HYS, 8'h00);
    wr(`OFS_CMP_DEB, 8'h01);
    c0_in <= 1'b0;
    repeat (40) @(posedge mclk);
    c0_in <= 1'b1;
    repeat (20) @(posedge mclk);
    #1 chk({7'h00, sel_out}, 8'h00);
    repeat (20) @(posedge mclk);
    #1 chk({7'h00, sel_out}, 8'h01);
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire
